//--- rtl/host_port_pkg.sv
// Constants, field layouts and types for the host port mode and buffer pointer block
//------------------------------------------------------------
// Notes on behaviour
// - Wait field sets ready-low buffer cycles
// - Auto wait holds ready low until ready
// - Transfer-method bit picks programmed I/O or DMA in AT mode
// - Gated DMA enable from host, mirrored read-only
// - DMA request answered by acknowledge or access
// - Auto interrupt in AT mode on enable set or stop-high write
// - Auto-command disable blocks write-class commands
// - Data-width bit selects 16-bit host transfers in AT mode
// - Host-variant bit selects XT or AT operation
// - Hardware reset sets mode register defaults
// - Reset-control write clears pointers, stop 01FFH
// - Reset-control write aborts host operation
// - Soft-reset bit holds buffer and host registers
// - Read pointer bytes cleared on any reset
// - Write pointer also cleared on auto command
// - Stop match ends transfer, sets done, overshoots
// - Stop-high write restarts an enabled transfer
//------------------------------------------------------------
package host_port_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] DMA_CONTROL_IDX       = 8'h53;
  localparam logic [7:0] HOST_PORT_MODE_IDX    = 8'h58;
  localparam logic [7:0] BUFFER_RESET_CTRL_IDX = 8'h59;
  localparam logic [7:0] READ_POINTER_LOW_IDX  = 8'h5A;
  localparam logic [7:0] READ_POINTER_HIGH_IDX = 8'h5B;
  localparam logic [7:0] WRITE_POINTER_LOW_IDX = 8'h5C;
  localparam logic [7:0] WRITE_POINTER_HIGH_IDX = 8'h5D;
  localparam logic [7:0] STOP_POINTER_LOW_IDX  = 8'h5E;
  localparam logic [7:0] STOP_POINTER_HIGH_IDX = 8'h5F;
  localparam logic [7:0] HOST_DMA_STATUS_IDX   = 8'h60;
  localparam logic [7:0] IRQ_STATUS_IDX        = 8'h61;
  localparam logic [7:0] IRQ_MASK_IDX          = 8'h62;

  // Values after reset
  localparam logic [7:0]  MODE_RESET      = 8'h58;
  localparam logic        SOFT_RST_RESET  = 1'b1;
  localparam logic [15:0] POINTER_RESET   = 16'h0000;
  localparam logic [15:0] STOP_RESET      = 16'h01FF;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;

  // Field positions
  localparam int HOST_WRITE_EN_BIT = 2;
  localparam int HOST_READ_EN_BIT  = 3;
  localparam int XFER_DONE_BIT     = 5;
  localparam int DMA_GATE_BIT      = 4;
  localparam int DMA_MIRROR_BIT    = 5;
  localparam int SOFT_RST_BIT      = 0;
  localparam int IRQ_DONE_BIT      = 0;
  localparam int IRQ_AUTO_GO_BIT   = 1;
  localparam int IRQ_AUTO_SKIP_BIT = 2;

  // Mode register layout, bit 7 first
  typedef struct packed {
    logic       host_variant_select;
    logic       data_width_16;
    logic       auto_cmd_disable;
    logic       auto_host_irq;
    logic       transfer_method_select;
    logic       auto_wait;
    logic [1:0] wait_cycle_field;
  } mode_type;

  // Host transfer sequencer
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_ACCESS = 2'b10,
    ST_HOLD   = 2'b11
  } xfer_state_type;

endpackage

//--- rtl/host_port_ctrl.sv
// Host port mode control, buffer reset and buffer address pointers with APB access
`timescale 1ns/10ps
module host_port_ctrl (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  // Host bus pins
  input  wire logic        host_iow_n_i,
  input  wire logic        host_ior_n_i,
  input  wire logic        host_dack_n_i,
  input  wire logic        host_dma_enable_i,
  input  wire logic [15:0] host_data_i,
  output logic      [15:0] host_data_o,
  output logic             host_data_oe_o,
  output logic             host_ready_o,
  output logic             host_dreq_o,
  output logic             host_irq_o,
  // Automatic command request from the task file logic
  input  wire logic        auto_cmd_i,
  input  wire logic        auto_cmd_write_class_i,
  output logic             auto_cmd_go_o,
  // Buffer memory port
  input  wire logic        buf_grant_i,
  input  wire logic [7:0]  buf_rdata_i,
  output logic             buf_req_o,
  output logic             buf_we_o,
  output logic      [15:0] buf_addr_o,
  output logic      [7:0]  buf_wdata_o
);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  host_port_pkg::mode_type       mode_ff, nxt_mode;
  host_port_pkg::xfer_state_type state_ff, nxt_state;
  logic        soft_rst_ff, nxt_soft_rst;
  logic [15:0] buffer_read_pointer_ff, nxt_buffer_read_pointer;
  logic [15:0] buffer_write_pointer_ff, nxt_buffer_write_pointer;
  logic [15:0] stop_ff, nxt_stop;
  logic        hwe_ff, nxt_hwe;
  logic        hre_ff, nxt_hre;
  logic        done_ff, nxt_done;
  logic        host_dma_gate_ff, nxt_host_dma_gate;
  logic [2:0]  irq_stat_ff, nxt_irq_stat;
  logic [2:0]  irq_mask_ff, nxt_irq_mask;
  logic [1:0]  wcnt_ff, nxt_wcnt;
  logic        byte_ff, nxt_byte;
  logic [15:0] hdata_out_ff, nxt_hdata_out;
  logic        hirq_ff, nxt_hirq;
  logic        go_ff, nxt_go;
  logic        pready_ff, nxt_pready;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [19:0] sync1_ff, sync2_ff;

  //------------------------------------------------------------
  // Decode and derived terms
  //------------------------------------------------------------
  logic [7:0] idx;
  logic       hit;
  logic       wr_en;
  logic       iow_s, ior_s, dack_s, host_dma_enable_s;
  logic       at_mode, wide, dma_mode, xfer_active, strobe, match;
  logic [7:0] rd_val;
  logic [15:0] act_ptr;

  assign idx               = paddr_i[9:2];
  assign wr_en             = psel_i & penable_i & pready_ff & pwrite_i & hit;
  assign iow_s             = sync2_ff[0];
  assign ior_s             = sync2_ff[1];
  assign dack_s            = sync2_ff[2];
  assign host_dma_enable_s = sync2_ff[3];
  assign at_mode  = ~mode_ff.host_variant_select;
  assign wide     = at_mode & mode_ff.data_width_16;
  assign dma_mode = at_mode & ~mode_ff.transfer_method_select;
  assign xfer_active = (hwe_ff | hre_ff) & ~done_ff & ~soft_rst_ff;
  // Acknowledge or plain programmed access both count as a strobe
  assign strobe   = hwe_ff ? ~iow_s : ~ior_s;
  assign act_ptr  = hre_ff ? buffer_read_pointer_ff : buffer_write_pointer_ff;
  // Full 16-bit compare; buffer-size masking lives outside this block
  assign match    = (act_ptr == stop_ff);

  // Register read mux and address hit
  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    case (idx)
      host_port_pkg::DMA_CONTROL_IDX: begin
        rd_val[host_port_pkg::HOST_WRITE_EN_BIT] = hwe_ff;
        rd_val[host_port_pkg::HOST_READ_EN_BIT]  = hre_ff;
        rd_val[host_port_pkg::XFER_DONE_BIT]     = done_ff;
      end
      host_port_pkg::HOST_PORT_MODE_IDX:     rd_val = mode_ff;
      host_port_pkg::BUFFER_RESET_CTRL_IDX:  rd_val = {7'h00, soft_rst_ff};
      host_port_pkg::READ_POINTER_LOW_IDX:   rd_val = buffer_read_pointer_ff[7:0];
      host_port_pkg::READ_POINTER_HIGH_IDX:  rd_val = buffer_read_pointer_ff[15:8];
      host_port_pkg::WRITE_POINTER_LOW_IDX:  rd_val = buffer_write_pointer_ff[7:0];
      host_port_pkg::WRITE_POINTER_HIGH_IDX: rd_val = buffer_write_pointer_ff[15:8];
      host_port_pkg::STOP_POINTER_LOW_IDX:   rd_val = stop_ff[7:0];
      host_port_pkg::STOP_POINTER_HIGH_IDX:  rd_val = stop_ff[15:8];
      host_port_pkg::HOST_DMA_STATUS_IDX: begin
        rd_val[host_port_pkg::DMA_GATE_BIT]   = host_dma_gate_ff;
        rd_val[host_port_pkg::DMA_MIRROR_BIT] = host_dma_enable_s;
      end
      host_port_pkg::IRQ_STATUS_IDX:         rd_val = {5'h00, irq_stat_ff};
      host_port_pkg::IRQ_MASK_IDX:           rd_val = {5'h00, irq_mask_ff};
      default:                               hit = 1'b0;
    endcase
  end

  //------------------------------------------------------------
  // Next-state logic
  //------------------------------------------------------------
  // Later assignments override earlier ones: bus, then transfer, then resets
  always_comb begin
    nxt_mode                 = mode_ff;
    nxt_state                = state_ff;
    nxt_soft_rst             = soft_rst_ff;
    nxt_buffer_read_pointer  = buffer_read_pointer_ff;
    nxt_buffer_write_pointer = buffer_write_pointer_ff;
    nxt_stop                 = stop_ff;
    nxt_hwe                  = hwe_ff;
    nxt_hre                  = hre_ff;
    nxt_done                 = done_ff;
    nxt_host_dma_gate        = host_dma_gate_ff;
    nxt_irq_stat             = irq_stat_ff;
    nxt_irq_mask             = irq_mask_ff;
    nxt_wcnt                 = wcnt_ff;
    nxt_byte                 = byte_ff;
    nxt_hdata_out            = hdata_out_ff;
    nxt_hirq                 = hirq_ff;
    nxt_go                   = 1'b0;
    // One wait state gives the read mux a register stage
    nxt_pready = psel_i & penable_i & ~pready_ff;
    nxt_prdata = pready_ff ? 32'h0000_0000 : {24'h00_0000, rd_val};

    // Firmware register writes
    if (wr_en) begin
      case (idx)
        host_port_pkg::HOST_PORT_MODE_IDX:     nxt_mode = pwdata_i[7:0];
        host_port_pkg::READ_POINTER_LOW_IDX:   nxt_buffer_read_pointer[7:0] = pwdata_i[7:0];
        host_port_pkg::READ_POINTER_HIGH_IDX:  nxt_buffer_read_pointer[15:8] = pwdata_i[7:0];
        host_port_pkg::WRITE_POINTER_LOW_IDX:  nxt_buffer_write_pointer[7:0] = pwdata_i[7:0];
        host_port_pkg::WRITE_POINTER_HIGH_IDX: nxt_buffer_write_pointer[15:8] = pwdata_i[7:0];
        host_port_pkg::STOP_POINTER_LOW_IDX:   nxt_stop[7:0] = pwdata_i[7:0];
        host_port_pkg::HOST_DMA_STATUS_IDX:    nxt_host_dma_gate = pwdata_i[host_port_pkg::DMA_GATE_BIT];
        host_port_pkg::IRQ_MASK_IDX:           nxt_irq_mask = pwdata_i[2:0];
        host_port_pkg::DMA_CONTROL_IDX: begin
          nxt_hwe = pwdata_i[host_port_pkg::HOST_WRITE_EN_BIT];
          nxt_hre = pwdata_i[host_port_pkg::HOST_READ_EN_BIT];
          if (pwdata_i[host_port_pkg::HOST_WRITE_EN_BIT] | pwdata_i[host_port_pkg::HOST_READ_EN_BIT]) begin
            nxt_done = 1'b0;
            nxt_hirq = mode_ff.auto_host_irq & at_mode;
          end
        end
        host_port_pkg::STOP_POINTER_HIGH_IDX: begin
          nxt_stop[15:8] = pwdata_i[7:0];
          if (hwe_ff | hre_ff) begin
            nxt_done  = 1'b0;
            nxt_state = host_port_pkg::ST_IDLE;
            nxt_hirq  = mode_ff.auto_host_irq & at_mode;
          end
        end
        host_port_pkg::IRQ_STATUS_IDX:         nxt_irq_stat = irq_stat_ff & ~pwdata_i[2:0];
        default:                               nxt_soft_rst = soft_rst_ff;
      endcase
    end

    // Host transfer sequencer
    case (state_ff)
      host_port_pkg::ST_IDLE: begin
        if (xfer_active & strobe) begin
          nxt_hirq = 1'b0;
          nxt_byte = 1'b0;
          // Acknowledged DMA cycles skip programmed waits
          nxt_wcnt = (dma_mode & ~dack_s) ? 2'd0 : mode_ff.wait_cycle_field;
          nxt_state = (dma_mode & ~dack_s) || (mode_ff.wait_cycle_field == 2'd0) ?
                      host_port_pkg::ST_ACCESS : host_port_pkg::ST_WAIT;
        end
      end
      host_port_pkg::ST_WAIT: begin
        nxt_wcnt = wcnt_ff - 2'd1;
        if (wcnt_ff == 2'd1) begin
          nxt_state = host_port_pkg::ST_ACCESS;
        end
      end
      host_port_pkg::ST_ACCESS: begin
        if (buf_grant_i) begin
          if (hre_ff) begin
            if (byte_ff) begin
              nxt_hdata_out[15:8] = buf_rdata_i;
            end else begin
              nxt_hdata_out[7:0] = buf_rdata_i;
            end
            nxt_buffer_read_pointer = buffer_read_pointer_ff + 16'h0001;
          end else begin
            nxt_buffer_write_pointer = buffer_write_pointer_ff + 16'h0001;
          end
          if (match) begin
            nxt_done  = 1'b1;
            nxt_state = host_port_pkg::ST_HOLD;
          end else if (wide & ~byte_ff) begin
            nxt_byte = 1'b1;
          end else begin
            nxt_state = host_port_pkg::ST_HOLD;
          end
        end
      end
      host_port_pkg::ST_HOLD: begin
        if (iow_s & ior_s) begin
          nxt_state = host_port_pkg::ST_IDLE;
        end
      end
      default: nxt_state = host_port_pkg::ST_IDLE;
    endcase

    // Automatic command issue; write-class commands may be suppressed
    if (auto_cmd_i & at_mode & ~soft_rst_ff) begin
      if (mode_ff.auto_cmd_disable & auto_cmd_write_class_i) begin
        nxt_irq_stat[host_port_pkg::IRQ_AUTO_SKIP_BIT] = 1'b1;
      end else begin
        nxt_go                   = 1'b1;
        nxt_irq_stat[host_port_pkg::IRQ_AUTO_GO_BIT] = 1'b1;
        nxt_buffer_write_pointer = host_port_pkg::POINTER_RESET;
        nxt_stop                 = host_port_pkg::STOP_RESET;
        nxt_hwe                  = 1'b1;
        nxt_hre                  = 1'b0;
        nxt_done                 = 1'b0;
        nxt_state                = host_port_pkg::ST_IDLE;
      end
    end

    // Done event; set wins over a same-cycle clear
    if (nxt_done & ~done_ff) begin
      nxt_irq_stat[host_port_pkg::IRQ_DONE_BIT] = 1'b1;
    end

    // Reset-control write or held soft reset
    if (wr_en && (idx == host_port_pkg::BUFFER_RESET_CTRL_IDX)) begin
      nxt_soft_rst = pwdata_i[host_port_pkg::SOFT_RST_BIT];
    end
    if ((wr_en && (idx == host_port_pkg::BUFFER_RESET_CTRL_IDX)) || soft_rst_ff) begin
      nxt_buffer_read_pointer  = host_port_pkg::POINTER_RESET;
      nxt_buffer_write_pointer = host_port_pkg::POINTER_RESET;
      nxt_stop                 = host_port_pkg::STOP_RESET;
      nxt_hwe                  = 1'b0;
      nxt_hre                  = 1'b0;
      nxt_done                 = 1'b0;
      nxt_state                = host_port_pkg::ST_IDLE;
      nxt_hirq                 = 1'b0;
      nxt_host_dma_gate        = 1'b0;
      nxt_go                   = 1'b0;
    end
  end

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  // Pin inputs pass two flip-flops before use
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_ff <= 20'hF_FFF7;
      sync2_ff <= 20'hF_FFF7;
    end else begin
      sync1_ff <= {host_data_i, host_dma_enable_i, host_dack_n_i, host_ior_n_i, host_iow_n_i};
      sync2_ff <= sync1_ff;
    end
  end

  // Control and pointer state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_ff                 <= host_port_pkg::MODE_RESET;
      state_ff                <= host_port_pkg::ST_IDLE;
      soft_rst_ff             <= host_port_pkg::SOFT_RST_RESET;
      buffer_read_pointer_ff  <= host_port_pkg::POINTER_RESET;
      buffer_write_pointer_ff <= host_port_pkg::POINTER_RESET;
      stop_ff                 <= host_port_pkg::STOP_RESET;
      hwe_ff                  <= 1'b0;
      hre_ff                  <= 1'b0;
      done_ff                 <= 1'b0;
      host_dma_gate_ff        <= 1'b0;
      irq_stat_ff             <= 3'h0;
      irq_mask_ff             <= host_port_pkg::IRQ_MASK_RESET;
      wcnt_ff                 <= 2'd0;
      byte_ff                 <= 1'b0;
      hdata_out_ff            <= 16'h0000;
      hirq_ff                 <= 1'b0;
      go_ff                   <= 1'b0;
      pready_ff               <= 1'b0;
      prdata_ff               <= 32'h0000_0000;
    end else begin
      mode_ff                 <= nxt_mode;
      state_ff                <= nxt_state;
      soft_rst_ff             <= nxt_soft_rst;
      buffer_read_pointer_ff  <= nxt_buffer_read_pointer;
      buffer_write_pointer_ff <= nxt_buffer_write_pointer;
      stop_ff                 <= nxt_stop;
      hwe_ff                  <= nxt_hwe;
      hre_ff                  <= nxt_hre;
      done_ff                 <= nxt_done;
      host_dma_gate_ff        <= nxt_host_dma_gate;
      irq_stat_ff             <= nxt_irq_stat;
      irq_mask_ff             <= nxt_irq_mask;
      wcnt_ff                 <= nxt_wcnt;
      byte_ff                 <= nxt_byte;
      hdata_out_ff            <= nxt_hdata_out;
      hirq_ff                 <= nxt_hirq;
      go_ff                   <= nxt_go;
      pready_ff               <= nxt_pready;
      prdata_ff               <= nxt_prdata;
    end
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  assign prdata_o  = prdata_ff;
  assign pready_o  = pready_ff;
  assign pslverr_o = pready_ff & psel_i & penable_i & ~hit;
  assign irq_o     = |(irq_stat_ff & irq_mask_ff);
  // Ready low through waits, and through a pending access when auto wait is on
  assign host_ready_o = ~((state_ff == host_port_pkg::ST_WAIT) |
                          ((state_ff == host_port_pkg::ST_ACCESS) & mode_ff.auto_wait) |
                          ((state_ff == host_port_pkg::ST_IDLE) & xfer_active & strobe &
                           mode_ff.auto_wait));
  assign host_data_o    = hdata_out_ff;
  assign host_data_oe_o = hre_ff & ~ior_s & (state_ff == host_port_pkg::ST_HOLD);
  // Request only between cycles, gated by the host enable when enabled
  assign host_dreq_o = dma_mode & xfer_active & (state_ff == host_port_pkg::ST_IDLE) &
                       (~host_dma_gate_ff | host_dma_enable_s);
  assign host_irq_o    = hirq_ff;
  assign auto_cmd_go_o = go_ff;
  assign buf_req_o     = (state_ff == host_port_pkg::ST_ACCESS);
  assign buf_we_o      = (state_ff == host_port_pkg::ST_ACCESS) & hwe_ff;
  assign buf_addr_o    = act_ptr;
  assign buf_wdata_o   = byte_ff ? sync2_ff[19:12] : sync2_ff[11:4];

endmodule // host_port_ctrl

//--- verification/host_buffer_model.sv
// Buffer memory model answering the block's buffer port
`timescale 1ns/10ps
module host_buffer_model (
  // Clock and stall select
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  // Buffer port
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic             grant_o,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:255];
  logic [1:0] dly_ff;
  logic [7:0] last_ff;
  // Grant at once, or after a three cycle stall when slow
  assign grant_o = req_i && (!slow_i || dly_ff == 2'h3);
  // Outside a grant the data lines show junk, not the last byte
  assign rdata_o = grant_o ? mem[addr_i[7:0]] : ~last_ff;
  // Stall counter and storage
  always @(posedge clk_i) begin
    dly_ff <= (req_i && !grant_o) ? dly_ff + 2'h1 : 2'h0;
    if (grant_o && we_i)
      mem[addr_i[7:0]] <= wdata_i;
    if (grant_o)
      last_ff <= mem[addr_i[7:0]];
  end
endmodule // host_buffer_model

//--- verification/host_port_monitor.sv
// Port checker for the host port control block
`timescale 1ns/10ps
module host_port_monitor (
  // Clock, reset and bus
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Command and buffer side
  input wire logic        auto_cmd_i,
  input wire logic        auto_cmd_go_o,
  input wire logic        host_data_oe_o,
  input wire logic        buf_req_o,
  input wire logic        buf_grant_i,
  input wire logic        buf_we_o,
  input wire logic [15:0] buf_addr_o
);
  //----------------------------------------
  // Properties
  //----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_apb_ans; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("bus answer late");
  property p_slverr; pslverr_o |-> pready_o; endproperty
  a_slverr: assert property (p_slverr) else $error("error without ready");
  property p_go_cause; auto_cmd_go_o |-> $past(auto_cmd_i); endproperty
  a_go_cause: assert property (p_go_cause) else $error("go without request");
  property p_go_pulse; auto_cmd_go_o |=> !auto_cmd_go_o; endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("go too long");
  property p_we_req; buf_we_o |-> buf_req_o; endproperty
  a_we_req: assert property (p_we_req) else $error("write outside request");
  // Abort by a bus write may drop a pending request
  property p_req_hold; buf_req_o && !buf_grant_i && !psel_i |=> buf_req_o && $stable(buf_addr_o); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_step; buf_req_o && buf_grant_i && !psel_i |=> buf_addr_o == $past(buf_addr_o) + 16'h1; endproperty
  a_step: assert property (p_step) else $error("pointer not stepped");
  property p_oe_read; host_data_oe_o |-> !buf_we_o; endproperty
  a_oe_read: assert property (p_oe_read) else $error("drive during write");
  c_go: cover property (auto_cmd_go_o);
  c_stall: cover property (buf_req_o && !buf_grant_i);
  c_err: cover property (pslverr_o);
endmodule // host_port_monitor
bind host_port_ctrl host_port_monitor mon_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .auto_cmd_i(auto_cmd_i),
  .auto_cmd_go_o(auto_cmd_go_o), .host_data_oe_o(host_data_oe_o), .buf_req_o(buf_req_o),
  .buf_grant_i(buf_grant_i), .buf_we_o(buf_we_o), .buf_addr_o(buf_addr_o));

//--- verification/tb_top.sv
// Self-checking bench for the host port control block
`timescale 1ns/10ps
module tb_top;
  logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, irq, e, iow_n = 1, ior_n = 1, dack_n = 1, dma_en = 0;
  logic [15:0] hdi = '0, hdo, baddr;
  logic        hoe, hrdy, dreq, hirq, acmd = 0, acw = 0, go, grant, breq, bwe, slow = 0;
  logic [7:0]  brd, bwd, q;
  int          fail_count = 0, cmp_count = 0, cyc = 0, lw;
  // Clock
  always #50 core_clk = ~core_clk;
  host_port_ctrl dut_u (.core_clk_i(core_clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .host_iow_n_i(iow_n), .host_ior_n_i(ior_n), .host_dack_n_i(dack_n),
    .host_dma_enable_i(dma_en), .host_data_i(hdi), .host_data_o(hdo), .host_data_oe_o(hoe),
    .host_ready_o(hrdy), .host_dreq_o(dreq), .host_irq_o(hirq), .auto_cmd_i(acmd),
    .auto_cmd_write_class_i(acw), .auto_cmd_go_o(go), .buf_grant_i(grant), .buf_rdata_i(brd),
    .buf_req_o(breq), .buf_we_o(bwe), .buf_addr_o(baddr), .buf_wdata_o(bwd));
  host_buffer_model pm_u (.clk_i(core_clk), .slow_i(slow), .req_i(breq), .we_i(bwe), .addr_i(baddr),
    .wdata_i(bwd), .grant_o(grant), .rdata_o(brd));
  //----------------------------------------
  // Shared tasks
  //----------------------------------------
  task automatic chk(input string n, input logic [15:0] g, x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  // Bus transfer; held until ready is seen high
  task automatic apb(input logic w, input logic [7:0] i, d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    // Ready, read data and release all at one rising edge; only the hang guard ends a wait
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rc(input logic [7:0] i, x);
    apb(0, i, 8'h00);
    chk($sformatf("reg %h", i), {8'h0, q}, {8'h0, x});
  endtask
  // One host strobe; counts wait cycles, keeps read byte
  task automatic hb(input logic rd, dk, input logic [7:0] d);
    @(posedge core_clk);
    hdi <= {8'h00, d};
    dack_n <= !dk;
    if (rd) ior_n <= 0;
    else iow_n <= 0;
    lw = 0;
    repeat (10) begin
      @(negedge core_clk);
      if (hrdy !== 1'b1) lw++;
    end
    q = hdo[7:0];
    if (rd) chk("data drive", {15'h0, hoe}, 16'h1);
    @(posedge core_clk);
    iow_n <= 1;
    ior_n <= 1;
    dack_n <= 1;
    hdi <= ~hdi;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic pulse(input logic w);
    @(posedge core_clk);
    acmd <= 1;
    acw <= w;
    @(posedge core_clk);
    acmd <= 0;
    lw = 0;
    repeat (4) begin
      @(negedge core_clk);
      if (go === 1'b1) lw++;
    end
  endtask
  // Reset values, held pointers, unmapped place
  task automatic t_regs();
    rc(8'h58, 8'h58);
    rc(8'h59, 8'h01);
    rc(8'h5E, 8'hFF);
    rc(8'h5F, 8'h01);
    apb(1, 8'h5B, 8'h34);
    rc(8'h5B, 8'h00);
    apb(0, 8'h00, 8'h00);
    chk("unmapped", {7'h0, e, q}, 16'h0100);
  endtask
  // Four host writes, one per wait code, ending on the stop pointer
  task automatic t_write();
    apb(1, 8'h59, 8'h00);
    apb(1, 8'h5C, 8'h10);
    apb(1, 8'h5E, 8'h13);
    apb(1, 8'h5F, 8'h00);
    apb(1, 8'h62, 8'h01);
    apb(1, 8'h58, 8'h18);
    apb(1, 8'h53, 8'h04);
    @(negedge core_clk);
    chk("host irq", {15'h0, hirq}, 16'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h58, 8'h18 | k[7:0]);
      hb(0, 0, 8'hA0 + k[7:0]);
      chk("wait cycles", 16'(lw), 16'(k));
    end
    chk("host irq off", {15'h0, hirq}, 16'h0);
    rc(8'h53, 8'h24);
    rc(8'h5C, 8'h14);
    chk("irq", {15'h0, irq}, 16'h1);
    apb(1, 8'h61, 8'h01);
    @(negedge core_clk);
    chk("irq clear", {15'h0, irq}, 16'h0);
  endtask
  // DMA reads with a stalling buffer: acknowledge, then plain access
  task automatic t_read();
    apb(1, 8'h58, 8'h14);
    apb(1, 8'h60, 8'h10);
    dma_en <= 1;
    apb(1, 8'h5A, 8'h10);
    apb(1, 8'h5E, 8'h11);
    rc(8'h60, 8'h30);
    apb(1, 8'h53, 8'h08);
    apb(1, 8'h5F, 8'h00);
    slow <= 1;
    repeat (2) @(negedge core_clk);
    chk("dreq", {15'h0, dreq}, 16'h1);
    @(posedge core_clk);
    dma_en <= 0;
    repeat (3) @(negedge core_clk);
    chk("dreq gated", {15'h0, dreq}, 16'h0);
    @(posedge core_clk);
    dma_en <= 1;
    repeat (3) @(negedge core_clk);
    hb(1, 1, 8'h00);
    chk("ack read", {8'h0, q}, 16'h00A0);
    chk("auto wait ack", 16'(lw), 16'd5);
    hb(1, 0, 8'h00);
    chk("pio read", {8'h0, q}, 16'h00A1);
    chk("auto wait pio", 16'(lw), 16'd5);
    chk("dreq end", {15'h0, dreq}, 16'h0);
    rc(8'h5A, 8'h12);
    slow <= 0;
  endtask
  task automatic t_ptr();
    apb(1, 8'h5B, 8'h12);
    apb(1, 8'h5D, 8'h56);
    rc(8'h5B, 8'h12);
    apb(1, 8'h59, 8'h00);
    rc(8'h5B, 8'h00);
    rc(8'h5D, 8'h00);
    rc(8'h5F, 8'h01);
  endtask
  task automatic t_auto();
    apb(1, 8'h61, 8'h07);
    apb(1, 8'h58, 8'h20);
    pulse(1);
    chk("go blocked", 16'(lw), 16'h0);
    rc(8'h61, 8'h04);
    apb(1, 8'h58, 8'h80);
    pulse(0);
    chk("go in xt", 16'(lw), 16'h0);
    apb(1, 8'h5C, 8'h77);
    apb(1, 8'h58, 8'h00);
    pulse(1);
    chk("go issued", 16'(lw), 16'h1);
    rc(8'h5C, 8'h00);
    // One strobe in 16-bit mode moves two bytes
    apb(1, 8'h58, 8'h48);
    hb(0, 0, 8'h5A);
    rc(8'h5C, 8'h02);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    t_regs();
    t_write();
    t_read();
    t_ptr();
    t_auto();
    complete_run();
  end
endmodule // tb_top
